// >>> rtl/duc_pkg.sv
/*
 * Constants, field layouts and types for the converter update control.
 * Assumes a 125 MHz clk; pin timing is resolved against that rate.
 */
// Operation
// - Busy low while computing converter code
// - Writes queue during computation; no output update
// - Load while idle transfers all channels
// - Load during computation stored, done afterwards
// - Reset holds busy low, interface off
// - Clear falling edge; loads ignored while low
// - Clear loads clear code into all channels
// - Clear keeps busy low 20/15 us
// - Reset pin falling edge restarts default sequence
// - Busy low through reset sequence, loads ignored
// - After reset only next falling edge counts
// - Frame low starts counting serial clocks
// - Two-wire mode: frame, chain pins address
// - Chain enable high cascades through serial out
// - Serial out changes on rising clock edges
// - Reference pin defaults to external input
// - Monitor select routes one channel out
// - Monitor select may route external inputs
// - Select pin high serial, low two-wire
// - Serial interface works during power down
package duc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int CLEAR_TIME_US_16 = 20;
	localparam int CLEAR_TIME_US_8 = 15;
	localparam int RESET_TIME_US = 270;
	localparam int CLEAR_CYC_16 = CLEAR_TIME_US_16 * CLK_MHZ;
	localparam int CLEAR_CYC_8 = CLEAR_TIME_US_8 * CLK_MHZ;
	localparam int RESET_CYC = RESET_TIME_US * CLK_MHZ;
	localparam int CALC_CYC = 4;

	// Serial frame layout
	localparam int FRAME_BITS = 24;
	localparam int FR_READ = 23;
	localparam int FR_TGT_HI = 22;
	localparam int FR_TGT_LO = 21;
	localparam int FR_CH_HI = 20;
	localparam int FR_CH_LO = 16;
	localparam int FR_DATA_HI = 15;
	localparam logic [1:0] TGT_SPECIAL = 2'h0;
	localparam logic [1:0] TGT_GAIN = 2'h1;
	localparam logic [1:0] TGT_OFFSET = 2'h2;
	localparam logic [1:0] TGT_INPUT = 2'h3;
	localparam logic [4:0] SPC_CLEAR_CODE = 5'h00;
	localparam logic [4:0] SPC_CONTROL = 5'h01;

	// Control word
	localparam int CTRL_W = 8;
	localparam int CT_INT_REF = 0;
	localparam int CT_MON_EN = 1;
	localparam int CT_MON_LO = 2;
	localparam int MON_SEL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

	// Synchronised pin vector
	localparam int PIN_LOAD = 0;
	localparam int PIN_CLEAR = 1;
	localparam int PIN_RESET = 2;
	localparam int PIN_SCLK = 3;
	localparam int PIN_FRAME = 4;
	localparam int PIN_SDIN = 5;
	localparam int PIN_CHAIN = 6;
	localparam int PIN_SEL = 7;
	localparam int PIN_PD = 8;
	localparam int NUM_PINS = 9;
	// Matches each pin's idle level so reset release shows no false edge
	localparam logic [NUM_PINS-1:0] PIN_IDLE = 9'h097;

	typedef enum logic [1:0] {
		DUC_RST,
		DUC_IDLE,
		DUC_CALC,
		DUC_CLEAR
	} duc_state_t;
endpackage

// >>> rtl/duc_sync_edge.sv
/*
 * Two-flop synchroniser with edge detection for a vector of pins.
 * Assumes the inputs are asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module duc_sync_edge #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins
	input wire logic [W-1:0] pin_in,
	// Synchronised
	output logic [W-1:0] level,
	output logic [W-1:0] fall,
	output logic [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} duc_sync_st_t;

	duc_sync_st_t r, r_nxt;

	always_comb begin
		r_nxt = r;
		r_nxt.s1 = pin_in;
		r_nxt.s2 = r.s1;
		r_nxt.s3 = r.s2;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '{s1: INIT, s2: INIT, s3: INIT};
		end else begin
			r <= r_nxt;
		end
	end

	// Edges from second and third flop only
	assign level = r.s2;
	assign fall = r.s3 & ~r.s2;
	assign rise = ~r.s3 & r.s2;
endmodule
`default_nettype wire

// >>> rtl/duc_serial_port.sv
/*
 * Serial frame receiver with readback and daisy-chain output.
 * Assumes already synchronised serial clock, frame and data levels.
 */
`timescale 1ns/100ps
`default_nettype none
module duc_serial_port (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Synchronised link
	input wire logic sclk_rise,
	input wire logic sclk_fall,
	input wire logic frame_fall,
	input wire logic frame_rise,
	input wire logic sdin,
	// Control
	input wire logic enable,
	input wire logic chain_en,
	input wire logic [duc_pkg::FRAME_BITS-1:0] tx_word,
	// Received word
	output logic word_valid,
	output logic [duc_pkg::FRAME_BITS-1:0] word,
	// Serial output
	output logic serial_out,
	output logic serial_out_oe_n
);
	import duc_pkg::*;

	localparam int CW = $clog2(FRAME_BITS + 1);

	typedef struct packed {
		logic active;
		logic [CW-1:0] cnt;
		logic [FRAME_BITS-1:0] sh_in;
		logic [FRAME_BITS-1:0] sh_out;
		logic so;
		logic oe_n;
		logic valid;
		logic [FRAME_BITS-1:0] word;
	} duc_ser_st_t;

	duc_ser_st_t r, r_nxt;

	always_comb begin
		r_nxt = r;
		r_nxt.valid = 1'b0;
		if (!enable) begin
			r_nxt.active = 1'b0;
			r_nxt.oe_n = 1'b1;
		end else if (frame_fall) begin
			r_nxt.active = 1'b1;
			r_nxt.cnt = '0;
			r_nxt.sh_out = tx_word;
			r_nxt.oe_n = 1'b0;
		end else if (frame_rise) begin
			if (r.active && chain_en && r.cnt == CW'(FRAME_BITS)) begin
				r_nxt.valid = 1'b1;
				r_nxt.word = r.sh_in;
			end
			r_nxt.active = 1'b0;
			r_nxt.oe_n = 1'b1;
		end else if (r.active) begin
			if (sclk_fall) begin
				// Host data is settled at the falling edge
				r_nxt.sh_in = {r.sh_in[FRAME_BITS-2:0], sdin};
				if (r.cnt != CW'(FRAME_BITS)) begin
					r_nxt.cnt = r.cnt + 1'b1;
				end
				if (!chain_en && r.cnt == CW'(FRAME_BITS - 1)) begin
					r_nxt.valid = 1'b1;
					r_nxt.word = {r.sh_in[FRAME_BITS-2:0], sdin};
					r_nxt.active = 1'b0;
				end
			end
			if (sclk_rise) begin
				// Chain passes on the word entered a frame earlier
				r_nxt.so = chain_en ? r.sh_in[FRAME_BITS-1]
					: r.sh_out[FRAME_BITS-1];
				r_nxt.sh_out = {r.sh_out[FRAME_BITS-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '{oe_n: 1'b1, default: '0};
		end else begin
			r <= r_nxt;
		end
	end

	assign word_valid = r.valid;
	assign word = r.word;
	assign serial_out = r.so;
	assign serial_out_oe_n = r.oe_n;
endmodule
`default_nettype wire

// >>> rtl/duc_update_control.sv
/*
 * Update sequencing of a multichannel converter: code calculation,
 * load queuing, clear to code, reset sequence, serial writes and
 * monitor/reference selection.
 * Assumes all strobes and link pins are asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module duc_update_control #(
	parameter int NUM_CH = 16,
	parameter int DATA_W = 14,
	parameter int RESET_CYCLES = duc_pkg::RESET_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Strobes
	input wire logic load_outputs_n,
	input wire logic clear_to_code_n,
	input wire logic reset_pin_n,
	// Link pins
	input wire logic sclk,
	input wire logic frame_sync_n,
	input wire logic serial_in,
	input wire logic chain_enable,
	input wire logic iface_spi_sel,
	input wire logic power_down_in,
	// Serial output
	output logic serial_out,
	output logic serial_out_oe_n,
	// Status
	output logic busy_n,
	output logic two_wire_mode,
	output logic [1:0] bus_address,
	// Converter codes
	output logic [NUM_CH*DATA_W-1:0] dac_codes,
	output logic dac_update,
	// Analog control
	output logic int_ref_enable,
	output logic mon_enable,
	output logic [duc_pkg::MON_SEL_W-1:0] mon_sel,
	output logic mon_from_input,
	output logic analog_power_down
);
	import duc_pkg::*;

	localparam int CLEAR_CYC = (NUM_CH == 8) ? CLEAR_CYC_8 : CLEAR_CYC_16;
	localparam int LONGEST = (RESET_CYCLES > CLEAR_CYC) ? RESET_CYCLES
		: CLEAR_CYC;
	localparam int CNT_W = $clog2(LONGEST + 1);
	localparam int CH_W = $clog2(NUM_CH);
	localparam logic [DATA_W-1:0] HALF = DATA_W'(1) << (DATA_W - 1);
	localparam logic [DATA_W-1:0] FULL = '1;

	generate
		if (!(NUM_CH == 8 || NUM_CH == 16) || DATA_W < 2
			|| DATA_W > FR_DATA_HI + 1 || RESET_CYCLES < 1) begin : g_chk
			$error("duc_update_control: unsupported parameters");
		end
	endgenerate

	typedef struct packed {
		duc_state_t st;
		logic [CNT_W-1:0] cnt;
		logic load_pend;
		logic [NUM_CH-1:0] dirty;
		logic [CH_W-1:0] calc_ch;
		logic [NUM_CH-1:0][DATA_W-1:0] x1;
		logic [NUM_CH-1:0][DATA_W-1:0] gain;
		logic [NUM_CH-1:0][DATA_W-1:0] offs;
		logic [NUM_CH-1:0][DATA_W-1:0] x2;
		logic [NUM_CH-1:0][DATA_W-1:0] dac;
		logic [DATA_W-1:0] clr_code;
		logic [CTRL_W-1:0] ctrl;
		logic [FRAME_BITS-1:0] rb;
		logic upd;
		logic [1:0] addr;
		logic pd;
	} duc_top_st_t;

	duc_top_st_t r, r_nxt;

	// Pin synchronisation
	logic [NUM_PINS-1:0] pin_lvl, pin_fall, pin_rise;

	duc_sync_edge #(
		.W(NUM_PINS),
		.INIT(PIN_IDLE)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({power_down_in, iface_spi_sel, chain_enable, serial_in,
			frame_sync_n, sclk, reset_pin_n, clear_to_code_n,
			load_outputs_n}),
		.level(pin_lvl),
		.fall(pin_fall),
		.rise(pin_rise)
	);

	logic spi_mode;
	logic ser_en;
	logic word_valid;
	logic [FRAME_BITS-1:0] word;

	assign spi_mode = pin_lvl[PIN_SEL];
	// Interface is off during the reset sequence and in two-wire mode
	assign ser_en = spi_mode && r.st != DUC_RST;

	duc_serial_port u_ser (
		.clk(clk),
		.sys_rst(sys_rst),
		.sclk_rise(pin_rise[PIN_SCLK]),
		.sclk_fall(pin_fall[PIN_SCLK]),
		.frame_fall(pin_fall[PIN_FRAME]),
		.frame_rise(pin_rise[PIN_FRAME]),
		.sdin(pin_lvl[PIN_SDIN]),
		.enable(ser_en),
		.chain_en(pin_lvl[PIN_CHAIN]),
		.tx_word(r.rb),
		.word_valid(word_valid),
		.word(word),
		.serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n)
	);

	// Lowest pending channel
	function automatic logic [CH_W-1:0] first_set(
		input logic [NUM_CH-1:0] v);
		logic [CH_W-1:0] idx;
		idx = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = CH_W'(i);
			end
		end
		return idx;
	endfunction

	// Gain and offset applied, clamped to the code range
	function automatic logic [DATA_W-1:0] calc_code(
		input logic [DATA_W-1:0] x1,
		input logic [DATA_W-1:0] m,
		input logic [DATA_W-1:0] c);
		logic [2*DATA_W-1:0] p;
		logic [DATA_W+1:0] s;
		p = (2*DATA_W)'(x1) * (2*DATA_W)'({1'b0, m} + 1'b1);
		s = {2'b00, p[2*DATA_W-1:DATA_W]} + {2'b00, c} - {2'b00, HALF};
		if (s[DATA_W+1]) begin
			return '0;
		end else if (s[DATA_W]) begin
			return FULL;
		end
		return s[DATA_W-1:0];
	endfunction

	logic load_ev, wr_ev;
	logic [1:0] w_tgt;
	logic [4:0] w_ch;
	logic [DATA_W-1:0] w_data;
	logic w_ch_ok;

	assign load_ev = pin_fall[PIN_LOAD] && pin_lvl[PIN_CLEAR];
	assign wr_ev = word_valid && r.st != DUC_RST;
	assign w_tgt = word[FR_TGT_HI:FR_TGT_LO];
	assign w_ch = word[FR_CH_HI:FR_CH_LO];
	assign w_data = word[DATA_W-1:0];
	assign w_ch_ok = 32'(w_ch) < NUM_CH;

	always_comb begin
		r_nxt = r;
		r_nxt.upd = 1'b0;
		r_nxt.pd = pin_lvl[PIN_PD];
		if (!spi_mode) begin
			r_nxt.addr = {pin_lvl[PIN_CHAIN], pin_lvl[PIN_FRAME]};
		end

		// Writes land in the input side at any time outside reset
		if (wr_ev && word[FR_READ]) begin
			r_nxt.rb = '0;
			case (w_tgt)
				TGT_SPECIAL: begin
					r_nxt.rb[DATA_W-1:0] = (w_ch == SPC_CONTROL)
						? DATA_W'(r.ctrl) : r.clr_code;
				end
				TGT_GAIN: r_nxt.rb[DATA_W-1:0] = r.gain[CH_W'(w_ch)];
				TGT_OFFSET: r_nxt.rb[DATA_W-1:0] = r.offs[CH_W'(w_ch)];
				default: r_nxt.rb[DATA_W-1:0] = r.x1[CH_W'(w_ch)];
			endcase
		end else if (wr_ev) begin
			case (w_tgt)
				TGT_SPECIAL: begin
					if (w_ch == SPC_CLEAR_CODE) begin
						r_nxt.clr_code = w_data;
					end else if (w_ch == SPC_CONTROL) begin
						r_nxt.ctrl = word[CTRL_W-1:0];
					end
				end
				TGT_GAIN: begin
					if (w_ch_ok) begin
						r_nxt.gain[CH_W'(w_ch)] = w_data;
					end
				end
				TGT_OFFSET: begin
					if (w_ch_ok) begin
						r_nxt.offs[CH_W'(w_ch)] = w_data;
					end
				end
				default: begin
					if (w_ch_ok) begin
						r_nxt.x1[CH_W'(w_ch)] = w_data;
					end
				end
			endcase
		end

		case (r.st)
			DUC_RST: begin
				// Loads are dropped, not stored
				r_nxt.load_pend = 1'b0;
				r_nxt.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(RESET_CYCLES - 1)) begin
					r_nxt.st = DUC_IDLE;
				end
			end
			DUC_IDLE: begin
				if (load_ev || r.load_pend) begin
					r_nxt.dac = r.x2;
					r_nxt.upd = 1'b1;
					r_nxt.load_pend = 1'b0;
				end
				if (r.dirty != '0) begin
					r_nxt.st = DUC_CALC;
					r_nxt.calc_ch = first_set(r.dirty);
					r_nxt.cnt = '0;
				end
			end
			DUC_CALC: begin
				if (load_ev) begin
					r_nxt.load_pend = 1'b1;
				end
				r_nxt.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(CALC_CYC - 1)) begin
					r_nxt.x2[r.calc_ch] = calc_code(r.x1[r.calc_ch],
						r.gain[r.calc_ch], r.offs[r.calc_ch]);
					r_nxt.dirty[r.calc_ch] = 1'b0;
					r_nxt.st = DUC_IDLE;
				end
			end
			DUC_CLEAR: begin
				if (load_ev) begin
					r_nxt.load_pend = 1'b1;
				end
				r_nxt.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(CLEAR_CYC - 1)) begin
					r_nxt.st = DUC_IDLE;
				end
			end
			default: r_nxt.st = DUC_RST;
		endcase

		// New writes mark channels; a mark set now beats the clear above
		if (wr_ev && !word[FR_READ] && w_tgt != TGT_SPECIAL && w_ch_ok) begin
			r_nxt.dirty[CH_W'(w_ch)] = 1'b1;
		end

		if (pin_fall[PIN_CLEAR] && r.st != DUC_RST) begin
			for (int i = 0; i < NUM_CH; i++) begin
				r_nxt.dac[i] = r.clr_code;
			end
			r_nxt.upd = 1'b1;
			r_nxt.load_pend = 1'b0;
			r_nxt.st = DUC_CLEAR;
			r_nxt.cnt = '0;
		end

		// Pin level is ignored; only a fresh falling edge restarts
		if (pin_fall[PIN_RESET]) begin
			r_nxt = '{st: DUC_RST, clr_code: r.clr_code, ctrl: r.ctrl,
				pd: r.pd, addr: r.addr, default: '0};
			for (int i = 0; i < NUM_CH; i++) begin
				r_nxt.gain[i] = FULL;
				r_nxt.offs[i] = HALF;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '{st: DUC_RST, ctrl: CTRL_RESET, default: '0};
			for (int i = 0; i < NUM_CH; i++) begin
				r.gain[i] <= FULL;
				r.offs[i] <= HALF;
			end
		end else begin
			r <= r_nxt;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_out
			assign dac_codes[g*DATA_W +: DATA_W] = r.dac[g];
		end
	endgenerate

	assign busy_n = (r.st == DUC_IDLE);
	assign dac_update = r.upd;
	assign two_wire_mode = !spi_mode;
	assign bus_address = r.addr;
	// Reference pin stays an input until software enables it
	assign int_ref_enable = r.ctrl[CT_INT_REF];
	assign mon_enable = r.ctrl[CT_MON_EN];
	assign mon_sel = r.ctrl[CT_MON_LO +: MON_SEL_W];
	assign mon_from_input = 32'(r.ctrl[CT_MON_LO +: MON_SEL_W])
		>= NUM_CH;
	assign analog_power_down = r.pd;
endmodule
`default_nettype wire

// >>> verification/duc_update_control_asserts.sv
/*
 * Port-level checker for the converter update control, bound below.
 * Assumes the top module's ports and the package constants.
 */
`timescale 1ns/100ps
`default_nettype none
module duc_update_control_asserts #(
	parameter int NUM_CH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins
	input wire logic clear_to_code_n,
	input wire logic reset_pin_n,
	input wire logic frame_sync_n,
	input wire logic chain_enable,
	input wire logic iface_spi_sel,
	input wire logic power_down_in,
	// Outputs
	input wire logic serial_out_oe_n,
	input wire logic busy_n,
	input wire logic two_wire_mode,
	input wire logic [1:0] bus_address,
	input wire logic dac_update,
	input wire logic [duc_pkg::MON_SEL_W-1:0] mon_sel,
	input wire logic mon_from_input,
	input wire logic analog_power_down
);
	import duc_pkg::*;
	logic [2:0] since_r;
	logic ok;
	// Synchroniser history is stale just after reset
	always_ff @(posedge clk) begin
		if (sys_rst)
			since_r <= 3'h0;
		else if (since_r != 3'h7)
			since_r <= since_r + 3'h1;
	end
	assign ok = since_r == 3'h7;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_rst_idle: assert property (disable iff (1'b0)
		sys_rst |=> !busy_n && serial_out_oe_n)
		else $error("busy or serial driver active in reset");
	a_reset_busy: assert property (ok && $fell(reset_pin_n)
		|-> ##[1:6] (!busy_n) [*8])
		else $error("busy not low after reset edge");
	a_clear_busy: assert property (ok && busy_n && $fell(clear_to_code_n)
		|-> ##[1:6] (!busy_n) [*8])
		else $error("busy not low after clear edge");
	a_mode_sel: assert property ((ok && $stable(iface_spi_sel)) [*4]
		|-> two_wire_mode == !iface_spi_sel)
		else $error("interface mode wrong");
	a_pd_follow: assert property ((ok && $stable(power_down_in)) [*4]
		|-> analog_power_down == power_down_in)
		else $error("power down not followed");
	a_addr_latch: assert property ((ok && two_wire_mode
		&& $stable({chain_enable, frame_sync_n})) [*4]
		|-> bus_address == {chain_enable, frame_sync_n})
		else $error("bus address wrong");
	a_oe_idle: assert property ((ok && frame_sync_n) [*4]
		|-> serial_out_oe_n)
		else $error("serial output driven outside frame");
	a_mon_src: assert property (mon_from_input == (mon_sel >= NUM_CH))
		else $error("monitor source wrong");
	a_update_pulse: assert property (dac_update |=> !dac_update)
		else $error("update pulse too long");
	c_busy_back: cover property ($rose(busy_n));
	c_clear: cover property (ok && busy_n && $fell(clear_to_code_n));
	c_two_wire: cover property (ok && two_wire_mode);
endmodule
bind duc_update_control duc_update_control_asserts #(.NUM_CH(NUM_CH))
	u_duc_update_control_asserts (.clk, .sys_rst, .clear_to_code_n,
	.reset_pin_n, .frame_sync_n, .chain_enable, .iface_spi_sel,
	.power_down_in, .serial_out_oe_n, .busy_n, .two_wire_mode,
	.bus_address, .dac_update, .mon_sel, .mon_from_input,
	.analog_power_down);
`default_nettype wire

// >>> verification/duc_host_model.sv
/*
 * Host serial controller: frame, serial clock and data, readback.
 * Assumes a 125 ns serial clock period, unrelated to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module duc_host_model (
	// Link
	output logic sclk,
	output logic frame_sync_n,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		sclk = 1'b0;
		frame_sync_n = 1'b1;
		serial_in = 1'b0;
	end
	// Clock stands still between frames; hold keeps a chain frame open
	task automatic send(input logic [23:0] w, input logic hold,
		output logic [23:0] rx);
		frame_sync_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			#62.5 sclk = 1'b1;
			serial_in = w[i];
			#62.5 sclk = 1'b0;
			rx[i] = serial_out;
		end
		#62.5 serial_in = ~serial_in;
		frame_sync_n = ~hold;
		// Frame stays high long enough to be seen between frames
		if (!hold) begin
			#125;
		end
	endtask
endmodule
`default_nettype wire

// >>> verification/test_duc_update_control.sv
/*
 * Self-checking bench for the converter update control.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module test_duc_update_control;
	import duc_pkg::*;
	localparam int DW = 14;
	localparam int RCYC = 50;
	logic clk, sys_rst, load_outputs_n, clear_to_code_n, reset_pin_n;
	logic sclk, frame_sync_n, serial_in, chain_enable, iface_spi_sel;
	logic power_down_in, serial_out, serial_out_oe_n, busy_n, dac_update;
	logic two_wire_mode, int_ref_enable, mon_enable, mon_from_input;
	logic analog_power_down;
	logic [1:0] bus_address;
	logic [16*DW-1:0] dac_codes;
	logic [MON_SEL_W-1:0] mon_sel;
	logic [23:0] rx;
	int failures = 0, n_checks = 0, upd_cnt = 0, low_len = 0, low_run = 0;
	duc_update_control #(.RESET_CYCLES(RCYC)) u_duc_update_control (.clk,
		.sys_rst, .load_outputs_n, .clear_to_code_n, .reset_pin_n, .sclk,
		.frame_sync_n, .serial_in, .chain_enable, .iface_spi_sel,
		.power_down_in, .serial_out, .serial_out_oe_n, .busy_n,
		.two_wire_mode, .bus_address, .dac_codes, .dac_update,
		.int_ref_enable, .mon_enable, .mon_sel, .mon_from_input,
		.analog_power_down);
	duc_host_model u_duc_host_model (.sclk, .frame_sync_n, .serial_in,
		.serial_out);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Mid-cycle sampling keeps counters ahead of the tasks reading them
	always @(negedge clk) begin
		if (dac_update === 1'b1)
			upd_cnt++;
		if (busy_n === 1'b0)
			low_run++;
		else if (low_run > 0) begin
			low_len = low_run;
			low_run = 0;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (e !== g) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_near(input string nm, input int e, g);
		n_checks++;
		if (g < e - 5 || g > e + 5) begin
			failures++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	function automatic logic [31:0] code(input int ch);
		return 32'(dac_codes[ch*DW +: DW]);
	endfunction
	task automatic frame(input logic rd, input logic [1:0] t,
		input logic [4:0] ch, input logic [15:0] d, input logic hold);
		u_duc_host_model.send({rd, t, ch, d}, hold, rx);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (12) @(posedge clk);
		while (busy_n !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		chk("busy_n idle", 1'b1, busy_n);
	endtask
	// Called at a clock edge; returns at one
	task automatic load_pulse;
		load_outputs_n <= 1'b0;
		repeat (4) @(posedge clk);
		load_outputs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_reset;
		int n;
		load_pulse;
		chk("busy_n", 1'b0, busy_n);
		wait_idle;
		n = upd_cnt;
		repeat (6) @(posedge clk);
		chk("updates", n, upd_cnt);
		chk("int_ref_enable", 1'b0, int_ref_enable);
		$display("test reset done");
	endtask
	task automatic t_load;
		frame(1'b0, TGT_INPUT, 5'h03, 16'h1234, 1'b0);
		wait_idle;
		chk_near("calc length", CALC_CYC, low_len);
		chk("code 3 before load", 32'h0, code(3));
		load_pulse;
		chk("code 3", 32'h1234, code(3));
		frame(1'b0, TGT_OFFSET, 5'h05, 16'h2100, 1'b0);
		frame(1'b0, TGT_INPUT, 5'h05, 16'h0100, 1'b0);
		wait_idle;
		load_pulse;
		chk("code 5 offset", 32'h0200, code(5));
		$display("test load done");
	endtask
	task automatic t_clear;
		int n;
		frame(1'b0, TGT_SPECIAL, SPC_CLEAR_CODE, 16'h0777, 1'b0);
		wait_idle;
		frame(1'b0, TGT_INPUT, 5'h07, 16'h0abc, 1'b0);
		wait_idle;
		n = upd_cnt;
		clear_to_code_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("code 3 cleared", 32'h0777, code(3));
		wait_idle;
		chk_near("clear length", CLEAR_CYC_16, low_len);
		load_pulse;
		chk("updates clear low", n + 1, upd_cnt);
		clear_to_code_n <= 1'b1;
		repeat (4) @(posedge clk);
		clear_to_code_n <= 1'b0;
		repeat (4) @(posedge clk);
		clear_to_code_n <= 1'b1;
		repeat (3) load_pulse;
		wait_idle;
		repeat (6) @(posedge clk);
		chk("updates stored", n + 3, upd_cnt);
		chk("code 7", 32'h0abc, code(7));
		$display("test clear done");
	endtask
	task automatic t_reset_pin;
		int n;
		frame(1'b0, TGT_INPUT, 5'h02, 16'h0155, 1'b0);
		wait_idle;
		reset_pin_n <= 1'b0;
		load_pulse;
		chk("busy_n in reset", 1'b0, busy_n);
		wait_idle;
		n = upd_cnt;
		repeat (6) @(posedge clk);
		chk("updates after reset", n, upd_cnt);
		chk_near("reset length", RCYC, low_len);
		load_pulse;
		chk("code 2 after reset", 32'h0, code(2));
		frame(1'b0, TGT_INPUT, 5'h02, 16'h0155, 1'b0);
		wait_idle;
		load_pulse;
		chk("code 2", 32'h0155, code(2));
		reset_pin_n <= 1'b1;
		$display("test reset pin done");
	endtask
	task automatic t_ctrl;
		logic [4:0] s;
		@(posedge clk) power_down_in <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			s = (i == 2) ? 5'h05 : 5'h10 + 5'(i);
			frame(1'b0, TGT_SPECIAL, SPC_CONTROL, {9'h0, s, 2'h3}, 1'b0);
			wait_idle;
			chk("mon_sel", s, mon_sel);
			chk("mon_from_input", s >= 5'h10, mon_from_input);
		end
		chk("int_ref_enable", 1'b1, int_ref_enable);
		chk("mon_enable", 1'b1, mon_enable);
		chk("analog_power_down", 1'b1, analog_power_down);
		power_down_in <= 1'b0;
		$display("test control done");
	endtask
	task automatic t_link;
		frame(1'b1, TGT_INPUT, 5'h02, 16'h0, 1'b0);
		frame(1'b1, TGT_INPUT, 5'h02, 16'h0, 1'b0);
		chk("readback", 32'h0155, rx[13:0]);
		@(posedge clk) chain_enable <= 1'b1;
		frame(1'b0, TGT_INPUT, 5'h04, 16'h0321, 1'b1);
		frame(1'b0, TGT_INPUT, 5'h04, 16'h0777, 1'b0);
		chk("chained out", {1'b0, TGT_INPUT, 5'h04, 16'h0321}, rx);
		wait_idle;
		load_pulse;
		chk("code 4", 32'h0777, code(4));
		chain_enable <= 1'b0;
		$display("test link done");
	endtask
	task automatic t_two_wire;
		@(posedge clk) iface_spi_sel <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			chain_enable <= i[0];
			repeat (6) @(posedge clk);
			chk("two_wire_mode", 1'b1, two_wire_mode);
			chk("bus_address", {i[0], 1'b1}, bus_address);
		end
		iface_spi_sel <= 1'b1;
		chain_enable <= 1'b0;
		$display("test two wire done");
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		load_outputs_n = 1'b1;
		clear_to_code_n = 1'b1;
		reset_pin_n = 1'b1;
		chain_enable = 1'b0;
		iface_spi_sel = 1'b1;
		power_down_in = 1'b0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		t_load;
		t_clear;
		t_reset_pin;
		t_ctrl;
		t_link;
		t_two_wire;
		end_of_test;
	end
	// Tests need about 11000 cycles
	initial begin
		#400000;
		failures++;
		end_of_test;
	end
endmodule
`default_nettype wire
